/* hdl/aoc_host_map.sv */
// Purpose: host memory map and configuration front end, eight analog outputs
// Assumes: 50 MHz i_clk, synchronous active-low reset taken as power-up
// Notes: switch pins are taken once after reset; store survives reset
`timescale 1ns/1ps
`include "aoc_params.svh"
module aoc_host_map (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host register port
  input wire logic [`AOC_AW-1:0] i_addr,
  input wire logic [`AOC_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`AOC_DW-1:0] o_rdata,
  // rear switches and supply monitors
  input wire logic [`AOC_NCH*`AOC_SW_GRP-1:0] i_range_sw,
  input wire logic [`AOC_NCH*`AOC_VSW_GRP-1:0] i_vrange_sw,
  input wire logic i_mode_sw,
  input wire logic i_hold_sw,
  input wire logic i_pc_pwr_ok,
  input wire logic i_rack_pwr_ok,
  // channel results
  output logic [`AOC_NCH-1:0][`AOC_DW-1:0] o_out,
  output aoc_pkg::aoc_chan_cfg_t [`AOC_NCH-1:0] o_cfg,
  output logic o_four_word,
  output logic o_hold_sel,
  output logic o_ready
);

  localparam int RW = `AOC_NCH * `AOC_SW_GRP;
  localparam int VW = `AOC_NCH * `AOC_VSW_GRP;
  localparam int PINW = RW + VW + $bits(aoc_pkg::aoc_pins_t);
  localparam int A_OUT0 = int'(`AOC_A_OUT0);
  localparam int A_LO0 = int'(`AOC_A_LO0);
  localparam int A_HI0 = int'(`AOC_A_HI0);
  localparam int A_PARAM0 = int'(`AOC_A_PARAM0);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [PINW-1:0] pin_meta;
  logic [PINW-1:0] pin_sync;
  aoc_pkg::aoc_pins_t pins;
  aoc_pkg::aoc_state_t st;
  aoc_pkg::aoc_state_t next_st;
  logic [1:0] boot_cnt;
  logic boot_take;
  logic four;
  logic hold;
  logic [`AOC_AW-1:0] ptr;
  logic [`AOC_DW-1:0] mem [`AOC_MEM_WORDS];
  logic [`AOC_DW-1:0] nv [`AOC_MEM_WORDS];
  logic nv_valid;
  logic wr_go;
  logic [`AOC_AW-1:0] wr_addr;
  logic save_prev;
  logic save_go;
  logic [`AOC_DW-1:0] rd_val;
  logic [`AOC_NCH-1:0] cfg_err;
  aoc_pkg::aoc_chan_cfg_t [`AOC_NCH-1:0] dec_cfg;
  aoc_pkg::aoc_status_t status;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {i_pc_pwr_ok, i_rack_pwr_ok, i_hold_sw, i_mode_sw, i_vrange_sw, i_range_sw};
      pin_sync <= pin_meta;
    end
  end

  assign pins = pin_sync[PINW-1:RW+VW];

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequence

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= aoc_pkg::AOC_S_INIT;
      boot_cnt <= 2'h0;
    end else begin
      st <= next_st;
      if (st == aoc_pkg::AOC_S_INIT) begin
        boot_cnt <= boot_cnt + 2'h1;
      end
    end
  end

  always_comb begin
    next_st = st;
    case (st)
      aoc_pkg::AOC_S_INIT: begin
        if (boot_take) begin
          next_st = aoc_pkg::AOC_S_LOAD;
        end
      end
      aoc_pkg::AOC_S_LOAD: next_st = aoc_pkg::AOC_S_RUN;
      aoc_pkg::AOC_S_RUN: next_st = aoc_pkg::AOC_S_RUN;
      default: next_st = aoc_pkg::AOC_S_INIT;
    endcase
  end

  // synchronisers are full by the time the count ends
  assign boot_take = (st == aoc_pkg::AOC_S_INIT) && (boot_cnt == `AOC_BOOT_WAIT);
  assign o_ready = (st == aoc_pkg::AOC_S_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // switch capture, once per power-up

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      four <= 1'b0;
      hold <= 1'b0;
      o_cfg <= '0;
    end else if (boot_take) begin
      four <= pins.four;
      hold <= pins.hold;
      o_cfg <= dec_cfg;
    end
  end

  assign o_four_word = four;
  assign o_hold_sel = hold;

  ////////////////////////////////////////////////////////////////////////////
  // host write decode

  always_comb begin
    wr_go = 1'b0;
    wr_addr = i_addr;
    if (i_wr && (st == aoc_pkg::AOC_S_RUN)) begin
      if (!four) begin
        wr_go = (i_addr != `AOC_A_STATUS) && (i_addr <= `AOC_A_LAST);
      end else if (i_addr == `AOC_IO_DATA) begin
        wr_addr = ptr;
        wr_go = (ptr != `AOC_A_STATUS) && (ptr <= `AOC_A_LAST);
      end
    end
  end

  // pointer word of the four-word allocation
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ptr <= '0;
    end else if (i_wr && four && (st == aoc_pkg::AOC_S_RUN) && (i_addr == `AOC_IO_PTR)) begin
      ptr <= i_wdata[`AOC_AW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory words and their nonvolatile copy

  assign save_go = mem[`AOC_A_CTRL][`AOC_CTRL_SAVE] && !save_prev && (st == aoc_pkg::AOC_S_RUN);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      save_prev <= 1'b0;
    end else begin
      save_prev <= mem[`AOC_A_CTRL][`AOC_CTRL_SAVE];
    end
  end

  // the store has no reset: it stands for what survives power-off
  always_ff @(posedge i_clk) begin
    if (save_go) begin
      nv_valid <= 1'b1;
    end
  end

  for (genvar w = 0; w < `AOC_MEM_WORDS; w++) begin : g_word
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        mem[w] <= '0;
      end else if ((st == aoc_pkg::AOC_S_LOAD) && nv_valid && (w >= A_PARAM0)) begin
        mem[w] <= nv[w];
      end else if (wr_go && (wr_addr == `AOC_AW'(w))) begin
        mem[w] <= i_wdata;
      end
    end

    always_ff @(posedge i_clk) begin
      if (save_go) begin
        nv[w] <= mem[w];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read path

  always_comb begin
    status = '0;
    status.four = four;
    status.hold = hold;
    status.run = (st == aoc_pkg::AOC_S_RUN);
    status.cfg_err = cfg_err;
  end

  function automatic logic [`AOC_DW-1:0] look(input logic [`AOC_AW-1:0] a);
    logic [`AOC_DW-1:0] v;
    v = '0;
    if (a == `AOC_A_STATUS) begin
      v = status;
    end else if (a <= `AOC_A_LAST) begin
      v = mem[a];
    end
    return v;
  endfunction

  always_comb begin
    rd_val = '0;
    if (!four) begin
      rd_val = look(i_addr);
    end else begin
      case (i_addr)
        `AOC_IO_PTR: rd_val = {{(`AOC_DW-`AOC_AW){1'b0}}, ptr};
        `AOC_IO_RDAT: rd_val = look(ptr);
        `AOC_IO_STAT: rd_val = status;
        default: rd_val = '0;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rd_val : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel decode, scaling window and output hold

  for (genvar c = 0; c < `AOC_NCH; c++) begin : g_ch
    logic signed [`AOC_DW-1:0] val;
    logic signed [`AOC_DW-1:0] lo;
    logic signed [`AOC_DW-1:0] hi;
    logic signed [`AOC_DW-1:0] mn;
    logic signed [`AOC_DW-1:0] mx;
    logic [`AOC_DW-1:0] scaled;

    aoc_range_decode u_dec (
      .i_grp(pin_sync[c*`AOC_SW_GRP +: `AOC_SW_GRP]),
      .i_vgrp(pin_sync[RW + c*`AOC_VSW_GRP +: `AOC_VSW_GRP]),
      .o_cfg(dec_cfg[c])
    );

    assign cfg_err[c] = o_cfg[c].cfg_err;
    assign val = mem[A_OUT0 + c];
    assign lo = mem[A_LO0 + c];
    assign hi = mem[A_HI0 + c];

    // reverse scaling swaps the limits
    always_comb begin
      mn = (lo <= hi) ? lo : hi;
      mx = (lo <= hi) ? hi : lo;
      scaled = val;
      if (mem[`AOC_A_SCALE_EN][c]) begin
        if (val < mn) begin
          scaled = mn;
        end else if (val > mx) begin
          scaled = mx;
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        o_out[c] <= '0;
      end else if (!pins.rack_ok || (st != aoc_pkg::AOC_S_RUN)) begin
        o_out[c] <= '0;
      end else if (!pins.pc_ok) begin
        o_out[c] <= hold ? o_out[c] : '0;
      end else begin
        o_out[c] <= scaled;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_boot_wait;
    (st == aoc_pkg::AOC_S_INIT) [*4];
  endsequence

  sequence s_load_run;
    (st == aoc_pkg::AOC_S_LOAD) ##1 (st == aoc_pkg::AOC_S_RUN);
  endsequence

  a_boot_order: assert property ($rose(i_rst_n) |-> s_boot_wait ##1 s_load_run)
    else $error("power-up sequence out of order");

  a_switch_frozen: assert property ((st == aoc_pkg::AOC_S_RUN) |=> $stable(o_cfg) && $stable(four))
    else $error("switch setting changed while running");

  a_direct_read: assert property (
    i_rd && !four && (i_addr != `AOC_A_STATUS) && (i_addr <= `AOC_A_LAST) && (st == aoc_pkg::AOC_S_RUN)
    |=> o_rdata == mem[$past(i_addr)])
    else $error("direct read returned wrong word");

  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside its cycle");

  a_direct_write: assert property (
    (st == aoc_pkg::AOC_S_RUN) && !four && i_wr && (i_addr >= `AOC_A_OUT0) && (i_addr <= `AOC_A_OUT_LAST)
    |=> mem[$past(i_addr)] == $past(i_wdata))
    else $error("direct write not stored");

  a_indirect_write: assert property (
    (st == aoc_pkg::AOC_S_RUN) && four && i_wr && (i_addr == `AOC_IO_DATA)
    && (ptr != `AOC_A_STATUS) && (ptr <= `AOC_A_LAST)
    |=> mem[$past(ptr)] == $past(i_wdata))
    else $error("indirect write not stored");

  a_four_unmapped: assert property (four && i_rd && (i_addr > `AOC_IO_STAT) |=> o_rdata == '0)
    else $error("four-word mode answered past its words");

  a_save_copy: assert property (save_go |=> nv[A_LO0] == $past(mem[A_LO0]) && nv_valid)
    else $error("save did not copy memory");

  a_reload_param: assert property ((st == aoc_pkg::AOC_S_LOAD) && nv_valid |=> mem[A_LO0] == $past(nv[A_LO0]))
    else $error("parameters not reloaded");

  a_zero_rack_loss: assert property (!pins.rack_ok |=> o_out == '0)
    else $error("output not zero after rack supply loss");

  a_zero_pc_loss: assert property (!hold && !pins.pc_ok |=> o_out == '0)
    else $error("output not zero after controller loss");

  a_hold_last: assert property (
    (st == aoc_pkg::AOC_S_RUN) && hold && pins.rack_ok && !pins.pc_ok |=> $stable(o_out))
    else $error("output not held on controller loss");

  a_err_status: assert property (
    i_rd && !four && (i_addr == `AOC_A_STATUS)
    |=> o_rdata[`AOC_DW-1 -: `AOC_NCH] == $past(cfg_err))
    else $error("configuration error not reported");

endmodule

/* hdl/aoc_params.svh */
// Purpose: constants for the analog output configuration host map
// Assumes: word addresses are six bits, data words sixteen bits
// Notes: definitions only
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH
`define AOC_MEM_WORDS 62
`define AOC_AW 6
`define AOC_DW 16
`define AOC_NCH 8
`define AOC_SW_GRP 3
`define AOC_VSW_GRP 4
// memory map word addresses
`define AOC_A_STATUS 6'h00
`define AOC_A_OUT0 6'h01
`define AOC_A_OUT_LAST 6'h08
`define AOC_A_PARAM0 6'h09
`define AOC_A_LO0 6'h09
`define AOC_A_HI0 6'h11
`define AOC_A_SCALE_EN 6'h19
`define AOC_A_CTRL 6'h1a
`define AOC_A_LAST 6'h3d
`define AOC_CTRL_SAVE 0
// allocated host words in four-word mode
`define AOC_IO_PTR 6'h00
`define AOC_IO_DATA 6'h01
`define AOC_IO_RDAT 6'h02
`define AOC_IO_STAT 6'h03
// power-up settle count before switches are taken
`define AOC_BOOT_WAIT 2'h3
// output signal range group codes, bit0 = pin 1
`define AOC_G_0_10V 3'h3
`define AOC_G_0_5V 3'h7
`define AOC_G_PM5V 3'h5
`define AOC_G_PM10V 3'h1
`define AOC_G_0_20MA 3'h2
`define AOC_G_4_20MA 3'h6
// voltage range group one-hot codes, bit0 = pin 1
`define AOC_V_PM10V 4'h8
`define AOC_V_PM5V 4'h4
`define AOC_V_0_10V 4'h2
`define AOC_V_0_5V 4'h1
`endif

/* hdl/aoc_pkg.sv */
// Purpose: shared types of the analog output configuration host map
// Assumes: nothing beyond the constants header
// Notes: types only
package aoc_pkg;

  typedef enum logic [2:0] {
    AOC_R_0_10V = 3'h0,
    AOC_R_0_5V = 3'h1,
    AOC_R_PM5V = 3'h2,
    AOC_R_PM10V = 3'h3,
    AOC_R_0_20MA = 3'h4,
    AOC_R_4_20MA = 3'h5,
    AOC_R_BAD = 3'h6
  } aoc_range_t;

  typedef struct packed {
    aoc_range_t range;
    logic cfg_err;
  } aoc_chan_cfg_t;

  typedef enum logic [2:0] {
    AOC_S_INIT = 3'h1,
    AOC_S_LOAD = 3'h2,
    AOC_S_RUN = 3'h4
  } aoc_state_t;

  typedef struct packed {
    logic pc_ok;
    logic rack_ok;
    logic hold;
    logic four;
  } aoc_pins_t;

  typedef struct packed {
    logic [7:0] cfg_err;
    logic [4:0] rsvd;
    logic run;
    logic hold;
    logic four;
  } aoc_status_t;

endpackage

/* hdl/aoc_range_decode.sv */
// Purpose: decode one channel's two range switch groups
// Assumes: a switch pin reads 1 when ON
// Notes: combinational; the caller samples the result once
`timescale 1ns/1ps
`include "aoc_params.svh"
module aoc_range_decode (
  // switch groups
  input wire logic [`AOC_SW_GRP-1:0] i_grp,
  input wire logic [`AOC_VSW_GRP-1:0] i_vgrp,
  // decoded setting
  output aoc_pkg::aoc_chan_cfg_t o_cfg
);

  aoc_pkg::aoc_range_t rng;
  aoc_pkg::aoc_range_t vrng;
  logic is_cur;

  always_comb begin
    case (i_grp)
      `AOC_G_0_10V: rng = aoc_pkg::AOC_R_0_10V;
      `AOC_G_0_5V: rng = aoc_pkg::AOC_R_0_5V;
      `AOC_G_PM5V: rng = aoc_pkg::AOC_R_PM5V;
      `AOC_G_PM10V: rng = aoc_pkg::AOC_R_PM10V;
      `AOC_G_0_20MA: rng = aoc_pkg::AOC_R_0_20MA;
      `AOC_G_4_20MA: rng = aoc_pkg::AOC_R_4_20MA;
      default: rng = aoc_pkg::AOC_R_BAD;
    endcase
    // only one pin may be on; anything else is invalid
    case (i_vgrp)
      `AOC_V_PM10V: vrng = aoc_pkg::AOC_R_PM10V;
      `AOC_V_PM5V: vrng = aoc_pkg::AOC_R_PM5V;
      `AOC_V_0_10V: vrng = aoc_pkg::AOC_R_0_10V;
      `AOC_V_0_5V: vrng = aoc_pkg::AOC_R_0_5V;
      default: vrng = aoc_pkg::AOC_R_BAD;
    endcase
    is_cur = (rng == aoc_pkg::AOC_R_0_20MA) || (rng == aoc_pkg::AOC_R_4_20MA);
    o_cfg.range = rng;
    // current ranges never look at the voltage group
    o_cfg.cfg_err = (rng == aoc_pkg::AOC_R_BAD) || (!is_cur && (vrng != rng));
  end

endmodule

/* tb/aoc_host_cpu.sv */
// Purpose: controller cpu model driving the host register port
// Assumes: one request at a time, strobes one cycle long
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
`include "aoc_params.svh"
module aoc_host_cpu (
  // clock
  input wire logic i_clk,
  // register port
  input wire logic [`AOC_DW-1:0] i_rdata,
  output logic [`AOC_AW-1:0] o_addr,
  output logic [`AOC_DW-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = '0;
    o_wdata = '0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // single word write; a block write is a run of these
  task automatic write(input logic [`AOC_AW-1:0] a, input logic [`AOC_DW-1:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  ////////////////////////////////////////////////////////////
  // read data taken in the cycle after the strobe
  task automatic read(input logic [`AOC_AW-1:0] a, output logic [`AOC_DW-1:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule

/* tb/aoc_host_map_bench.sv */
// Purpose: self-checking bench for the host map
// Assumes: switch ON reads 1, power pins act after three edges
// Notes: each boot is a reset with new switch settings
`timescale 1ns/1ps
`include "aoc_params.svh"
module aoc_host_map_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] range_sw = {8{`AOC_G_0_10V}};
  logic [31:0] vrange_sw = {8{`AOC_V_0_10V}};
  logic mode_sw = 1'b0;
  logic hold_sw = 1'b0;
  logic pc_ok = 1'b1;
  logic rack_ok = 1'b1;
  logic [5:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [7:0][15:0] o_out;
  aoc_pkg::aoc_chan_cfg_t [7:0] o_cfg;
  logic o_four;
  logic o_hold;
  logic o_ready;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] v;

  always #10 clk = ~clk;

  aoc_host_cpu u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  aoc_host_map u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_range_sw(range_sw), .i_vrange_sw(vrange_sw), .i_mode_sw(mode_sw),
    .i_hold_sw(hold_sw), .i_pc_pwr_ok(pc_ok), .i_rack_pwr_ok(rack_ok), .o_out(o_out), .o_cfg(o_cfg),
    .o_four_word(o_four), .o_hold_sel(o_hold), .o_ready(o_ready));

  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 6000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    u_host.read(a, v);
    chk("read data", v, e);
  endtask

  task automatic boot(input logic m, input logic h);
    int n;
    n = 0;
    // at time zero reset already stands low
    if (rst_n) begin
      @(posedge clk);
    end
    rst_n <= 1'b0;
    mode_sw <= m;
    hold_sw <= h;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("out in reset", o_out[0], 16'h0);
    while (o_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ready", 16'(o_ready), 16'h1);
    chk("four word", 16'(o_four), 16'(m));
    chk("hold sel", 16'(o_hold), 16'(h));
  endtask

  ////////////////////////////////////////////////////////////
  // direct writes to every channel, refused and unmapped places
  task automatic t_two_word();
    boot(1'b0, 1'b0);
    for (int c = 0; c < 8; c++) u_host.write(6'(c + 1), 16'h1000 + 16'(c));
    for (int c = 0; c < 8; c++) begin
      rdchk(6'(c + 1), 16'h1000 + 16'(c));
      chk("chan out", o_out[c], 16'h1000 + 16'(c));
    end
    u_host.write(6'h00, 16'hffff);
    rdchk(6'h00, 16'h0004);
    u_host.write(6'h3d, 16'h5a5a);
    rdchk(6'h3d, 16'h5a5a);
    rdchk(6'h3e, 16'h0000);
  endtask

  // controller and rack supply loss, default and hold
  task automatic t_power();
    @(posedge clk);
    pc_ok <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("pc loss zero", o_out[0], 16'h0);
    @(posedge clk);
    pc_ok <= 1'b1;
    repeat (4) @(posedge clk);
    boot(1'b0, 1'b1);
    u_host.write(6'h01, 16'h1234);
    pc_ok <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("pc loss hold", o_out[0], 16'h1234);
    @(posedge clk);
    rack_ok <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("rack loss", o_out[0], 16'h0);
    @(posedge clk);
    pc_ok <= 1'b1;
    rack_ok <= 1'b1;
  endtask

  // every range code, bad and mismatched groups, late switch change
  task automatic t_ranges();
    logic [2:0] g [8] = '{`AOC_G_0_10V, `AOC_G_0_5V, `AOC_G_PM5V, `AOC_G_PM10V, `AOC_G_0_20MA,
      `AOC_G_4_20MA, 3'h0, `AOC_G_0_5V};
    logic [3:0] w [8] = '{4'h3, `AOC_V_0_5V, `AOC_V_PM5V, `AOC_V_PM10V, 4'hf, 4'h0, `AOC_V_0_10V,
      `AOC_V_0_10V};
    for (int c = 0; c < 8; c++) begin
      range_sw[3*c +: 3] <= g[c];
      vrange_sw[4*c +: 4] <= w[c];
    end
    boot(1'b0, 1'b0);
    @(posedge clk);
    range_sw <= {8{`AOC_G_0_10V}};
    vrange_sw <= {8{`AOC_V_0_10V}};
    repeat (4) @(posedge clk);
    #1;
    // channel 6 carries an unused group code, so its range is the invalid code
    for (int c = 0; c < 7; c++) chk("range", 16'(o_cfg[c].range), 16'(c));
    chk("range", 16'(o_cfg[7].range), 16'(aoc_pkg::AOC_R_0_5V));
    for (int c = 0; c < 8; c++) chk("cfg err", 16'(o_cfg[c].cfg_err), 16'(c == 0 || c > 5));
    rdchk(6'h00, 16'hc104);
    boot(1'b0, 1'b0);
    for (int c = 0; c < 8; c++) chk("factory", 16'(o_cfg[c]), 16'h0);
  endtask

  // indirect access through the allocated words
  task automatic t_four_word();
    boot(1'b1, 1'b0);
    u_host.write(`AOC_IO_PTR, 16'h0005);
    u_host.write(`AOC_IO_DATA, 16'hbeef);
    rdchk(`AOC_IO_RDAT, 16'hbeef);
    chk("chan out", o_out[4], 16'hbeef);
    rdchk(`AOC_IO_STAT, 16'h0005);
    // refused writes: read-data word, then data word with the pointer on status
    u_host.write(`AOC_IO_RDAT, 16'h1111);
    u_host.write(`AOC_IO_PTR, 16'h0000);
    u_host.write(`AOC_IO_DATA, 16'h2222);
    rdchk(`AOC_IO_DATA, 16'h0000);
    rdchk(6'h04, 16'h0000);
    rdchk(`AOC_IO_PTR, 16'h0000);
    rdchk(`AOC_IO_STAT, 16'h0005);
    u_host.write(`AOC_IO_PTR, 16'h0005);
    rdchk(`AOC_IO_RDAT, 16'hbeef);
  endtask

  // scaling window, then save and reload of a parameter
  task automatic t_scale_save();
    boot(1'b0, 1'b0);
    u_host.write(`AOC_A_LO0, 16'h000a);
    u_host.write(`AOC_A_HI0, 16'h0064);
    u_host.write(`AOC_A_SCALE_EN, 16'h0001);
    u_host.write(6'h01, 16'h01f4);
    repeat (2) @(posedge clk);
    #1;
    chk("scaled high", o_out[0], 16'h0064);
    u_host.write(6'h01, 16'h0005);
    repeat (2) @(posedge clk);
    #1;
    chk("scaled low", o_out[0], 16'h000a);
    u_host.write(`AOC_A_CTRL, 16'h0000);
    u_host.write(`AOC_A_CTRL, 16'h0001);
    repeat (2) @(posedge clk);
    u_host.write(`AOC_A_LO0, 16'h0022);
    boot(1'b0, 1'b0);
    rdchk(`AOC_A_LO0, 16'h000a);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    t_two_word();
    t_power();
    t_ranges();
    t_four_word();
    t_scale_save();
    wrap_up();
  end
endmodule
